// [design/hdisp_pkg.sv]
// Shared constants for the two-wire haptic driver slave port and its master
package hdisp_pkg;
  localparam int          BYTE_W        = 8;
  localparam int          ADDR_W        = 7;
  localparam logic [6:0]  OWN_ADDR      = 7'h5A;
  localparam logic [6:0]  BCAST_ADDR    = 7'h58;
  localparam logic        DIR_WRITE     = 1'b0;
  localparam logic        DIR_READ      = 1'b1;
  localparam logic [2:0]  LAST_BIT      = 3'h7;
  localparam logic [3:0]  ACK_SLOT      = 4'h8;
  localparam logic [7:0]  PTR_RESET     = 8'h00;
  // Master bit timing: four quarters per bus clock period
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          SCL_PERIOD_NS = 2500;
  localparam int          QTR_CYC       = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam logic [7:0]  QTR_LAST      = 8'(QTR_CYC - 1);
  typedef logic [BYTE_W-1:0] hdisp_byte_t;
endpackage

// [design/hdisp_if.sv]
// Open-drain two-wire bus joining master and slave ends
`timescale 1ns/1ns
interface hdisp_if;
  logic scl;        // Resolved clock line level
  logic sda;        // Resolved data line level
  logic m_scl_o;    // Master clock drive value, always low
  logic m_scl_oe;   // Master pulls clock low
  logic m_sda_o;    // Master data drive value, always low
  logic m_sda_oe;   // Master pulls data low
  logic s_sda_o;    // Slave data drive value, always low
  logic s_sda_oe;   // Slave pulls data low

  // Wired-AND with pull-ups: any enabled low driver wins
  assign scl = ~(m_scl_oe & ~m_scl_o);
  assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));

  modport master (input scl, input sda, output m_scl_o, output m_scl_oe,
                  output m_sda_o, output m_sda_oe);
  modport slave  (input scl, input sda, output s_sda_o, output s_sda_oe);
endinterface

// [design/hdisp_master.sv]
// Bus master end: byte-level command port driving the two-wire bus
`timescale 1ns/1ns
module hdisp_master
  import hdisp_pkg::*;
(
  input  wire logic         clk,          // System clock
  input  wire logic         sys_rst,      // Synchronous reset, active high
  hdisp_if.master           bus,          // Two-wire bus
  input  wire logic         cmd_valid,    // Byte command offered
  output logic              cmd_ready,    // Command can be taken
  input  wire logic         cmd_start,    // Send (repeated) start first
  input  wire logic         cmd_stop,     // Send stop after the byte
  input  wire logic         cmd_read,     // Receive a byte instead of send
  input  wire logic         cmd_last,     // Read: answer not-acknowledge
  input  wire hdisp_byte_t  cmd_data,     // Byte to send
  output logic              rsp_valid,    // Byte finished, one cycle
  output hdisp_byte_t       rsp_data,     // Byte received or sent
  output logic              rsp_nack,     // Acknowledge slot was high
  output logic              busy          // Bus owned, start to stop
);
  import hdisp_pkg::*;

  typedef enum {M_IDLE, M_START, M_BIT, M_STOP, M_HOLD} hdisp_mst_e;

  hdisp_mst_e   state_r;
  logic [7:0]   div_r;
  logic [1:0]   ph_r;
  logic [3:0]   bit_r;
  hdisp_byte_t  sh_r;
  logic         rd_r;
  logic         last_r;
  logic         stop_r;
  logic         nack_r;
  logic         scl_oe_r;
  logic         sda_oe_r;
  logic [1:0]   sda_q;
  logic         qtick;

  assign bus.m_scl_o  = 1'b0;
  assign bus.m_sda_o  = 1'b0;
  assign bus.m_scl_oe = scl_oe_r;
  assign bus.m_sda_oe = sda_oe_r;
  assign qtick        = (div_r == QTR_LAST);

  ////////////////////////////////////////////////////////////////////////////
  // Data line synchroniser; the bus is asynchronous to clk
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      sda_q <= 2'h3;
    else
      sda_q <= {sda_q[0], bus.sda};
  end

  // Quarter-period divider; only runs while a symbol is in progress
  always_ff @(posedge clk)
  begin
    if (sys_rst || state_r == M_IDLE || state_r == M_HOLD || qtick)
      div_r <= 8'h00;
    else
      div_r <= div_r + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Symbol sequencer: start, nine-bit byte slots, stop
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_r   <= M_IDLE;
      ph_r      <= 2'h0;
      bit_r     <= 4'h0;
      sh_r      <= 8'h00;
      rd_r      <= 1'b0;
      last_r    <= 1'b0;
      stop_r    <= 1'b0;
      nack_r    <= 1'b0;
      scl_oe_r  <= 1'b0;
      sda_oe_r  <= 1'b0;
      cmd_ready <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_data  <= 8'h00;
      rsp_nack  <= 1'b0;
      busy      <= 1'b0;
    end
    else
    begin
      rsp_valid <= 1'b0;
      case (state_r)
        M_IDLE, M_HOLD:
        begin
          if (cmd_valid && cmd_ready)
          begin
            cmd_ready <= 1'b0;
            busy      <= 1'b1;
            sh_r      <= cmd_data;
            rd_r      <= cmd_read;
            last_r    <= cmd_last;
            stop_r    <= cmd_stop;
            ph_r      <= 2'h0;
            bit_r     <= 4'h0;
            // An idle bus always needs a start first
            state_r   <= (cmd_start || state_r == M_IDLE) ? M_START : M_BIT;
          end
        end
        M_START:
          // Same shape for first and repeated start
          if (qtick)
          begin
            ph_r <= ph_r + 2'h1;
            case (ph_r)
              2'h0: sda_oe_r <= 1'b0;
              2'h1: scl_oe_r <= 1'b0;
              2'h2: sda_oe_r <= 1'b1;
              default:
              begin
                scl_oe_r <= 1'b1;
                state_r  <= M_BIT;
              end
            endcase
          end
        M_BIT:
          if (qtick)
          begin
            ph_r <= ph_r + 2'h1;
            case (ph_r)
              // Data set up only while the clock is low
              2'h0:
                if (bit_r == ACK_SLOT)
                  sda_oe_r <= rd_r & ~last_r;
                else
                  sda_oe_r <= ~rd_r & ~sh_r[BYTE_W-1];
              2'h1: scl_oe_r <= 1'b0;
              2'h2:
                if (bit_r == ACK_SLOT)
                  nack_r <= sda_q[1];
                else
                  sh_r <= {sh_r[BYTE_W-2:0], sda_q[1]};
              default:
              begin
                scl_oe_r <= 1'b1;
                if (bit_r == ACK_SLOT)
                begin
                  rsp_valid <= 1'b1;
                  rsp_data  <= sh_r;
                  rsp_nack  <= nack_r;
                  state_r   <= stop_r ? M_STOP : M_HOLD;
                  cmd_ready <= ~stop_r;
                end
                else
                  bit_r <= bit_r + 4'h1;
              end
            endcase
          end
        M_STOP:
          if (qtick)
          begin
            ph_r <= ph_r + 2'h1;
            case (ph_r)
              2'h0: sda_oe_r <= 1'b1;
              2'h1: scl_oe_r <= 1'b0;
              2'h2: sda_oe_r <= 1'b0;
              default:
              begin
                state_r   <= M_IDLE;
                cmd_ready <= 1'b1;
                busy      <= 1'b0;
              end
            endcase
          end
        default: state_r <= M_IDLE;
      endcase
    end
  end
endmodule

// [design/hdisp_slave.sv]
// Device end: two-wire slave with register pointer and auto-increment
`timescale 1ns/1ns
// Notes on behaviour
// - Bytes are eight bits, MSB first
// - Receiver acknowledges in the following clock period
// - Data edges with clock high: start, stop
// - Data changes only while the clock is low
// - Acknowledge own address 0x5A, both directions
// - Acknowledge holds data low whole period
// - Lines only pulled low, wired-AND
// - No limit on bytes per transfer
// - Master ends each transfer with stop
// - All registers reachable singly or in bursts
// - First write byte sets pointer, rest follow
// - Master sends direction zero for writes
// - Acknowledge address, pointer and data bytes
// - Read: pointer write, repeated start, read
// - Keep sending successive registers while acknowledged
// - Master acknowledges all but last read byte
// - Master ends read with not-acknowledge, stop
// - Also respond to broadcast address 0x58
module hdisp_slave
  import hdisp_pkg::*;
(
  input  wire logic         clk,        // System clock
  input  wire logic         sys_rst,    // Synchronous reset, active high
  hdisp_if.slave            bus,        // Two-wire bus
  output logic              wr_valid,   // Register write strobe, one cycle
  output hdisp_byte_t       wr_addr,    // Register written
  output hdisp_byte_t       wr_data,    // Value written
  output hdisp_byte_t       rd_addr,    // Register pointer for reads
  input  wire hdisp_byte_t  rd_data,    // Contents at rd_addr, same cycle
  output logic              selected    // Addressed since last start
);
  import hdisp_pkg::*;

  typedef enum {S_IDLE, S_ADDR, S_ACK_A, S_PTR, S_ACK_P, S_WDATA, S_ACK_W,
                S_RDATA, S_RACK, S_IGNORE} hdisp_slv_e;

  hdisp_slv_e   state_r;
  logic [1:0]   scl_q;
  logic [1:0]   sda_q;
  logic         scl_d;
  logic         sda_d;
  hdisp_byte_t  sh_r;
  logic [2:0]   cnt_r;
  logic         full_r;
  logic         sda_oe_r;
  hdisp_byte_t  ptr_r;
  logic         scl_rise;
  logic         scl_fall;
  logic         start_det;
  logic         stop_det;

  // True when a received address byte names this device
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    addr_hit = (a == OWN_ADDR) || (a == BCAST_ADDR);
  endfunction

  assign bus.s_sda_o  = 1'b0;
  assign bus.s_sda_oe = sda_oe_r;
  assign rd_addr      = ptr_r;

  ////////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers, then one more stage for edge finding
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      scl_q <= 2'h3;
      sda_q <= 2'h3;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_q <= {scl_q[0], bus.scl};
      sda_q <= {sda_q[0], bus.sda};
      scl_d <= scl_q[1];
      sda_d <= sda_q[1];
    end
  end

  // Bus events; both lines pass the same delay so their order is kept
  assign scl_rise  = scl_q[1] & ~scl_d;
  assign scl_fall  = ~scl_q[1] & scl_d;
  assign start_det = scl_q[1] & scl_d & sda_d & ~sda_q[1];
  assign stop_det  = scl_q[1] & scl_d & ~sda_d & sda_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Protocol engine. Drive changes follow a seen clock fall, so they always
  // land in the low phase even with the synchroniser delay.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_r  <= S_IDLE;
      sh_r     <= 8'h00;
      cnt_r    <= 3'h0;
      full_r   <= 1'b0;
      sda_oe_r <= 1'b0;
      ptr_r    <= PTR_RESET;
      wr_valid <= 1'b0;
      wr_addr  <= 8'h00;
      wr_data  <= 8'h00;
      selected <= 1'b0;
    end
    else
    begin
      wr_valid <= 1'b0;
      if (start_det)
      begin
        // A start ends any burst; the pointer survives for the read phase
        state_r  <= S_ADDR;
        cnt_r    <= 3'h0;
        full_r   <= 1'b0;
        sda_oe_r <= 1'b0;
        selected <= 1'b0;
      end
      else if (stop_det)
      begin
        state_r  <= S_IDLE;
        sda_oe_r <= 1'b0;
        selected <= 1'b0;
      end
      else
      begin
        case (state_r)
          S_ADDR, S_PTR, S_WDATA:
            if (scl_rise)
            begin
              sh_r   <= {sh_r[BYTE_W-2:0], sda_q[1]};
              cnt_r  <= cnt_r + 3'h1;
              full_r <= (cnt_r == LAST_BIT);
            end
            else if (scl_fall && full_r)
            begin
              full_r <= 1'b0;
              if (state_r == S_ADDR)
              begin
                if (addr_hit(sh_r[BYTE_W-1:1]))
                begin
                  sda_oe_r <= 1'b1;
                  selected <= 1'b1;
                  state_r  <= S_ACK_A;
                end
                else
                  state_r  <= S_IGNORE;
              end
              else if (state_r == S_PTR)
              begin
                ptr_r    <= sh_r;
                sda_oe_r <= 1'b1;
                state_r  <= S_ACK_P;
              end
              else
              begin
                wr_valid <= 1'b1;
                wr_addr  <= ptr_r;
                wr_data  <= sh_r;
                ptr_r    <= ptr_r + 8'h01;
                sda_oe_r <= 1'b1;
                state_r  <= S_ACK_W;
              end
            end
          S_ACK_A:
            // Acknowledge held through the whole high phase
            if (scl_fall)
            begin
              cnt_r <= 3'h0;
              if (sh_r[0] == DIR_READ)
              begin
                sh_r     <= rd_data;
                sda_oe_r <= ~rd_data[BYTE_W-1];
                ptr_r    <= ptr_r + 8'h01;
                state_r  <= S_RDATA;
              end
              else
              begin
                sda_oe_r <= 1'b0;
                state_r  <= S_PTR;
              end
            end
          S_ACK_P, S_ACK_W:
            if (scl_fall)
            begin
              sda_oe_r <= 1'b0;
              cnt_r    <= 3'h0;
              state_r  <= S_WDATA;
            end
          S_RDATA:
            if (scl_fall)
            begin
              if (cnt_r == LAST_BIT)
              begin
                sda_oe_r <= 1'b0;
                state_r  <= S_RACK;
              end
              else
              begin
                sh_r     <= {sh_r[BYTE_W-2:0], 1'b0};
                sda_oe_r <= ~sh_r[BYTE_W-2];
                cnt_r    <= cnt_r + 3'h1;
              end
            end
          S_RACK:
            if (scl_rise && sda_q[1])
              state_r <= S_IGNORE;
            else if (scl_fall)
            begin
              // Master acknowledged: next register follows
              sh_r     <= rd_data;
              sda_oe_r <= ~rd_data[BYTE_W-1];
              ptr_r    <= ptr_r + 8'h01;
              cnt_r    <= 3'h0;
              state_r  <= S_RDATA;
            end
          S_IDLE, S_IGNORE:
            sda_oe_r <= 1'b0;
          default:
            state_r <= S_IDLE;
        endcase
      end
    end
  end
endmodule

// [verif/hdisp_assertions.sv]
// Bus-level checks on the two-wire link between master and slave ends
`timescale 1ns/1ns
module hdisp_assertions
  import hdisp_pkg::*;
(
  input wire logic clk,      // System clock
  input wire logic sys_rst,  // Sync reset, high
  input wire logic scl,      // Clock line
  input wire logic sda,      // Data line
  input wire logic m_scl_o,  // Master clock value
  input wire logic m_scl_oe, // Master clock pull
  input wire logic m_sda_o,  // Master data value
  input wire logic m_sda_oe, // Master data pull
  input wire logic s_sda_o,  // Slave data value
  input wire logic s_sda_oe  // Slave data pull
);
  logic       scl_r;   // Clock line one cycle ago
  logic       sda_r;   // Data line one cycle ago
  logic [3:0] bit_r;   // Rises since start, ack slot at 8
  logic [7:0] sh_r;    // Bits of the current byte
  logic       first_r; // Current byte is the address
  logic       hit_r;   // Address matched this device
  logic       rd_r;    // Matched address asked to read
  logic       nak_r;   // Master refused a read byte
  logic       start_ev, stop_ev, rise_ev, ack_ev, match;

  ////////////////////////////////////////////////////////////////////////////
  // Edge and condition decode, one cycle behind the wire
  assign start_ev = scl && scl_r && sda_r && !sda;
  assign stop_ev  = scl && scl_r && !sda_r && sda;
  assign rise_ev  = scl && !scl_r;
  assign ack_ev   = rise_ev && (bit_r == 4'h8);
  assign match    = (sh_r[7:1] == OWN_ADDR) || (sh_r[7:1] == BCAST_ADDR);

  // Line history
  always_ff @(posedge clk)
  begin
    scl_r <= scl;
    sda_r <= sda;
  end

  // Bit position; start and stop realign it so a cut byte is forgotten
  always_ff @(posedge clk)
  begin
    if (sys_rst || start_ev || stop_ev)
      bit_r <= 4'h0;
    else if (rise_ev)
      bit_r <= (bit_r == 4'h8) ? 4'h0 : bit_r + 4'h1;
  end

  // Byte shifter, ack slot excluded
  always_ff @(posedge clk)
  begin
    if (rise_ev && bit_r != 4'h8)
      sh_r <= {sh_r[6:0], sda};
  end

  // Address byte flag
  always_ff @(posedge clk)
  begin
    if (sys_rst || ack_ev || stop_ev)
      first_r <= 1'h0;
    else if (start_ev)
      first_r <= 1'h1;
  end

  // Selection and direction, taken at the address ack slot
  always_ff @(posedge clk)
  begin
    if (sys_rst || start_ev || stop_ev)
    begin
      hit_r <= 1'h0;
      rd_r  <= 1'h0;
    end
    else if (ack_ev && first_r)
    begin
      hit_r <= match;
      rd_r  <= sh_r[0];
    end
  end

  // Read refused by the master
  always_ff @(posedge clk)
  begin
    if (sys_rst || start_ev || stop_ev)
      nak_r <= 1'h0;
    else if (ack_ev && !first_r && hit_r && rd_r && sda)
      nak_r <= 1'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_high_hold;
    scl[*8];
  endsequence

  sequence s_held_low;
    s_sda_oe[*8];
  endsequence

  AST_DRIVE_LOW: assert property (!m_scl_o && !m_sda_o && !s_sda_o)
    else $error("a bus drive value is not low");
  AST_SLV_EDGE_LOW: assert property ($changed(s_sda_oe) |-> !scl)
    else $error("slave moved data while clock high");
  // Master may move data with the clock high only to make start or stop
  AST_MST_EDGE_LOW: assert property
    ($changed(m_sda_oe) && scl |-> start_ev || stop_ev)
    else $error("master moved data while clock high");
  AST_ACK_HOLD: assert property
    (s_sda_oe && $rose(scl) |-> s_held_low)
    else $error("slave let go of data in a clock high phase");
  AST_START_GAP: assert property (start_ev |-> s_high_hold)
    else $error("clock fell too soon after start");
  AST_ADDR_ACK: assert property
    (ack_ev && first_r && match |-> s_sda_oe)
    else $error("matching address not acknowledged");
  AST_ADDR_NAK: assert property
    (ack_ev && first_r && !match |-> !s_sda_oe)
    else $error("foreign address acknowledged");
  AST_WR_ACK: assert property
    (ack_ev && !first_r && hit_r && !rd_r |-> s_sda_oe)
    else $error("written byte not acknowledged");
  AST_RD_FREE: assert property
    (ack_ev && !first_r && hit_r && rd_r |-> !s_sda_oe)
    else $error("slave held data in master ack slot");
  AST_NAK_QUIET: assert property (nak_r |-> !s_sda_oe)
    else $error("slave drove data after not-acknowledge");
endmodule

// [verif/testbench.sv]
// Self-checking bench joining master and slave ends over the two-wire bus
`timescale 1ns/1ns
`define CHK(nm, ex, got) \
  begin \
    cmp_count++; \
    if ((got) !== (ex)) \
    begin \
      error_cnt++; \
      $display("[ERR] %s expected %h seen %h", nm, ex, got); \
    end \
  end
module testbench;
  import hdisp_pkg::*;
  logic        clk, sys_rst, cmd_valid, cmd_ready, cmd_start, cmd_stop;
  logic        cmd_read, cmd_last, rsp_valid, rsp_nack, busy, wr_valid;
  logic        selected;
  hdisp_byte_t cmd_data, rsp_data, wr_addr, wr_data, rd_addr, rd_data;
  hdisp_byte_t regs [256];  // Register file behind the slave
  logic [15:0] wlog [$];    // Writes seen: address, data
  int          error_cnt, cmp_count;

  hdisp_if hdisp_if_inst ();
  hdisp_master hdisp_master_inst (.clk(clk), .sys_rst(sys_rst),
    .bus(hdisp_if_inst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_start(cmd_start), .cmd_stop(cmd_stop), .cmd_read(cmd_read),
    .cmd_last(cmd_last), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_nack(rsp_nack), .busy(busy));
  hdisp_slave hdisp_slave_inst (.clk(clk), .sys_rst(sys_rst),
    .bus(hdisp_if_inst), .wr_valid(wr_valid), .wr_addr(wr_addr),
    .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data),
    .selected(selected));
  hdisp_assertions hdisp_assertions_inst (.clk(clk), .sys_rst(sys_rst),
    .scl(hdisp_if_inst.scl), .sda(hdisp_if_inst.sda),
    .m_scl_o(hdisp_if_inst.m_scl_o), .m_scl_oe(hdisp_if_inst.m_scl_oe),
    .m_sda_o(hdisp_if_inst.m_sda_o), .m_sda_oe(hdisp_if_inst.m_sda_oe),
    .s_sda_o(hdisp_if_inst.s_sda_o), .s_sda_oe(hdisp_if_inst.s_sda_oe));

  ////////////////////////////////////////////////////////////////////////////
  // Register file: read is combinational, as the slave samples it at once
  assign rd_data = regs[rd_addr];
  always @(posedge clk)
    if (wr_valid === 1'h1)
    begin
      regs[wr_addr] <= wr_data;
      wlog.push_back({wr_addr, wr_data});
    end

  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // One byte and its ack slot; one shared bound so a stuck bus cannot hang
  task automatic xfer(input logic st, sp, rd, ls, input hdisp_byte_t d,
                      input hdisp_byte_t ex, input logic ex_nak);
    int n;
    n = 0;
    cmd_valid = 1'h1;
    cmd_start = st;
    cmd_stop  = sp;
    cmd_read  = rd;
    cmd_last  = ls;
    cmd_data  = d;
    while (cmd_ready !== 1'h1 && n < 20000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    #1;
    cmd_valid = 1'h0;
    while (rsp_valid !== 1'h1 && n < 20000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 20000)
    begin
      error_cnt++;
      $display("[ERR] rsp_valid expected 1 seen %b", rsp_valid);
      final_report();
    end
    else
    begin
      `CHK("byte", ex, rsp_data)
      `CHK("ack", ex_nak, rsp_nack)
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_idle();
    `CHK("scl idle", 1'h1, hdisp_if_inst.scl)
    `CHK("sda idle", 1'h1, hdisp_if_inst.sda)
    `CHK("busy idle", 1'h0, busy)
    `CHK("pointer", PTR_RESET, rd_addr)
    $display("test idle done");
  endtask

  // Burst write wrapping the pointer through 0xFF
  task automatic t_write();
    wlog.delete();
    xfer(1'h1, 1'h0, 1'h0, 1'h0, {OWN_ADDR, DIR_WRITE}, 8'hB4, 1'h0);
    `CHK("selected", 1'h1, selected)
    `CHK("busy", 1'h1, busy)
    xfer(1'h0, 1'h0, 1'h0, 1'h0, 8'hFE, 8'hFE, 1'h0);
    xfer(1'h0, 1'h0, 1'h0, 1'h0, 8'hA5, 8'hA5, 1'h0);
    xfer(1'h0, 1'h0, 1'h0, 1'h0, 8'h3C, 8'h3C, 1'h0);
    xfer(1'h0, 1'h1, 1'h0, 1'h0, 8'h81, 8'h81, 1'h0);
    `CHK("write 0", 16'hFEA5, wlog[0])
    `CHK("write 1", 16'hFF3C, wlog[1])
    `CHK("write 2", 16'h0081, wlog[2])
    $display("test write done");
  endtask

  // Pointer write, repeated start, burst read ending in not-acknowledge
  task automatic t_read();
    xfer(1'h1, 1'h0, 1'h0, 1'h0, {OWN_ADDR, DIR_WRITE}, 8'hB4, 1'h0);
    xfer(1'h0, 1'h0, 1'h0, 1'h0, 8'hFE, 8'hFE, 1'h0);
    xfer(1'h1, 1'h0, 1'h0, 1'h0, {OWN_ADDR, DIR_READ}, 8'hB5, 1'h0);
    xfer(1'h0, 1'h0, 1'h1, 1'h0, 8'h00, 8'hA5, 1'h0);
    xfer(1'h0, 1'h0, 1'h1, 1'h0, 8'h00, 8'h3C, 1'h0);
    xfer(1'h0, 1'h1, 1'h1, 1'h1, 8'h00, 8'h81, 1'h1);
    `CHK("pointer", 8'h01, rd_addr)
    $display("test read done");
  endtask

  // Single write and single read through the broadcast address 0x58
  task automatic t_bcast();
    xfer(1'h1, 1'h0, 1'h0, 1'h0, 8'hB0, 8'hB0, 1'h0);
    xfer(1'h0, 1'h0, 1'h0, 1'h0, 8'h20, 8'h20, 1'h0);
    xfer(1'h0, 1'h1, 1'h0, 1'h0, 8'h5E, 8'h5E, 1'h0);
    xfer(1'h1, 1'h0, 1'h0, 1'h0, 8'hB0, 8'hB0, 1'h0);
    xfer(1'h0, 1'h0, 1'h0, 1'h0, 8'h20, 8'h20, 1'h0);
    xfer(1'h1, 1'h0, 1'h0, 1'h0, 8'hB1, 8'hB1, 1'h0);
    xfer(1'h0, 1'h1, 1'h1, 1'h1, 8'h00, 8'h5E, 1'h1);
    $display("test broadcast done");
  endtask

  // Address one bit off the own address must be ignored
  task automatic t_bad();
    int n0;
    n0 = wlog.size();
    xfer(1'h1, 1'h0, 1'h0, 1'h0, {7'h5B, DIR_WRITE}, 8'hB6, 1'h1);
    `CHK("selected", 1'h0, selected)
    xfer(1'h0, 1'h1, 1'h0, 1'h0, 8'h20, 8'h20, 1'h1);
    `CHK("writes", n0, wlog.size())
    `CHK("kept", 8'h5E, regs[8'h20])
    $display("test bad address done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_rst   = 1'h1;
    cmd_valid = 1'h0;
    cmd_start = 1'h0;
    cmd_stop  = 1'h0;
    cmd_read  = 1'h0;
    cmd_last  = 1'h0;
    cmd_data  = 8'h00;
    error_cnt = 0;
    cmp_count = 0;
    foreach (regs[i])
      regs[i] = 8'h00;
    repeat (2) @(posedge clk);
    #1;
    sys_rst = 1'h0;
    repeat (4) @(posedge clk);
    #1;
    t_idle();
    t_write();
    t_read();
    t_bcast();
    t_bad();
    final_report();
  end
endmodule
